//--- pkg/bpi_pkg.sv
`default_nettype none
package bpi_pkg;
   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] OFS_CMD     = 8'h00;
   localparam logic [7:0] OFS_DATA_LO = 8'h04;
   localparam logic [7:0] OFS_DATA_HI = 8'h08;
   localparam logic [7:0] OFS_STATUS  = 8'h0c;
   localparam logic [7:0] OFS_PERIOD  = 8'h10;

   // ************************************************************
   // Command codes and axis field
   // ************************************************************
   localparam logic [7:0] CMD_STAGE_DATA   = 8'h06;
   localparam logic [7:0] CMD_MODE_SET     = 8'h2a;
   localparam logic [7:0] CMD_BP_DRIVE     = 8'h66;
   localparam logic [7:0] CMD_HOLD_START   = 8'h77;
   localparam logic [7:0] CMD_HOLD_RELEASE = 8'h78;
   localparam logic [7:0] CMD_STOP_DECEL   = 8'h26;
   localparam logic [7:0] CMD_STOP_INSTANT = 8'h27;
   localparam int         CMD_AXIS_LSB     = 8;
   localparam logic [1:0] AXIS_X           = 2'h1;
   localparam logic [1:0] AXIS_Y           = 2'h2;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int ST_COUNT_LSB    = 12;
   localparam int ST_NEXT_BIT     = 11;
   localparam int ST_HOLD_BIT     = 1;
   localparam int ST_DRIVE_BIT    = 0;
   localparam int MODE_EN_BIT     = 0;
   localparam int MODE_SPD_LO_BIT = 6;
   localparam int MODE_SPD_HI_BIT = 7;

   // ************************************************************
   // Sizes, reset values and timing
   // ************************************************************
   localparam int         PAT_W        = 16;
   localparam int         STAGE_W      = 4 * PAT_W;
   localparam int         STAGES       = 8;
   localparam int         CNT_W        = 4;
   localparam logic [3:0] CNT_FULL     = 4'h8;
   localparam logic [3:0] CNT_LAST     = 4'h7;
   localparam logic [3:0] CNT_HALF     = 4'h4;
   localparam logic [3:0] BIT_LAST     = 4'hf;
   localparam logic [15:0] MODE_RST    = 16'h0000;
   localparam int         CLK_NS       = 5;
   localparam int         STEP_RST_NS  = 1000;
   localparam logic [15:0] PERIOD_RST  = 16'(STEP_RST_NS / CLK_NS);
   localparam logic [8:0] VEC_NUM      = 9'h16a;
   localparam int         VEC_SHIFT    = 8;

   typedef enum logic [1:0] {
      BPI_IDLE = 2'b00,
      BPI_RUN  = 2'b01
   } bpi_state_t;

   // Period scaled by about 1.414 for diagonal steps
   function automatic logic [15:0] bpi_stretch(input logic [15:0] p);
      logic [24:0] prod;
      prod = 25'(p) * 25'(VEC_NUM);
      return prod[VEC_SHIFT +: 16];
   endfunction

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] bpi_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                             input logic [1:0] sel);
      logic [15:0] r;
      r = old_v;
      if (sel[0]) begin
         r[7:0] = new_v[7:0];
      end
      if (sel[1]) begin
         r[15:8] = new_v[15:8];
      end
      return r;
   endfunction
endpackage
`default_nettype wire

//--- logic/bpi_pacer.sv
`timescale 1ns/1ps
`default_nettype none
module bpi_pacer (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Control
   input  wire logic        en_i,
   input  wire logic [15:0] period_i,
   input  wire logic        stretch_i,
   // Step enable
   output logic             tick_o
);
   import bpi_pkg::*;

   logic [15:0] cnt;
   logic [15:0] limit;

   // ************************************************************
   // Period divider
   // ************************************************************
   always_comb begin
      limit = stretch_i ? bpi_stretch(period_i) : period_i;
      if (limit == 16'h0000) begin
         limit = 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         cnt    <= 16'h0000;
         tick_o <= 1'b0;
      end else if (cnt + 16'h0001 >= limit) begin
         cnt    <= 16'h0000;
         tick_o <= 1'b1;
      end else begin
         cnt    <= cnt + 16'h0001;
         tick_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- logic/bpi_prebuffer.sv
`timescale 1ns/1ps
`default_nettype none
module bpi_prebuffer (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Control
   input  wire logic        push_i,
   input  wire logic        pop_i,
   input  wire logic        flush_i,
   input  wire logic [63:0] data_i,
   // State
   output logic [63:0]      head_o,
   output logic [3:0]       count_o
);
   import bpi_pkg::*;

   logic [STAGE_W-1:0] mem [STAGES];
   logic [2:0]         wr_ptr;
   logic [2:0]         rd_ptr;
   logic               do_push;
   logic               do_pop;

   assign do_push = push_i && (count_o != CNT_FULL);
   assign do_pop  = pop_i && (count_o != 4'h0);
   assign head_o  = mem[rd_ptr];

   // ************************************************************
   // Eight stage storage
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (do_push && !flush_i) begin
         mem[wr_ptr] <= data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || flush_i) begin
         wr_ptr  <= 3'h0;
         rd_ptr  <= 3'h0;
         count_o <= 4'h0;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + 3'h1;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + 3'h1;
         end
         count_o <= count_o + {3'h0, do_push} - {3'h0, do_pop};
      end
   end
endmodule
`default_nettype wire

//--- logic/bpi_top.sv
// Operation
// - Drive command pushes stage and starts
// - Drive command needs no axis selection
// - Hold on X blocks start until release
// - Plus and minus both set ends interpolation
// - Drain queued stages then end normally
// - Eight stages of four 16-bit words
// - Stack count in status bits 15 to 12
// - Sixteen bits done: pop, next stage
// - Next-stage flag while count 1 to 7
// - Stop command on X flushes the stage buffer
// - Any active limit stops driving
// - Interrupt low on 8 to 7, 4 to 3
// - Interrupt cleared by drive command or finish
// - Simple mode stretches diagonal step period
// - Mode bit 7 has no effect on vector speed
// - Finish-point command stages pattern words
// - Pattern words emitted from bit 0 upward
// - Mode bit 0 enables interpolation
// - Mode bit 6 alone selects vector speed stretch
`timescale 1ns/1ps
`default_nettype none
module bpi_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Limits: x plus, x minus, y plus, y minus
   input  wire logic [3:0]  limit_i,
   // Step outputs
   output logic             x_plus_step_o,
   output logic             x_minus_step_o,
   output logic             y_plus_step_o,
   output logic             y_minus_step_o,
   output logic             driving_o,
   output logic             continuous_interp_irq_n_o
);
   import bpi_pkg::*;

   // Registers and state
   bpi_state_t  state;
   logic [15:0] data_low_register;
   logic [15:0] data_high_register;
   logic [15:0] mode;
   logic [15:0] period;
   logic [31:0] stage_x;
   logic [31:0] stage_y;
   logic        hold;
   logic        started;
   logic        diag;
   logic [3:0]  bit_idx;

   // Buffer and pacer
   logic [63:0] head;
   logic [3:0]  count;
   logic        tick;

   // Bus decode
   logic        wr_req;
   logic        rd_req;
   logic        cmd_wr;
   logic [7:0]  cmd_code;
   logic [1:0]  cmd_axis;

   // Drive control
   logic        push;
   logic        push_ok;
   logic        pop;
   logic        flush;
   logic        stop_cmd;
   logic        end_code;
   logic        finish;
   logic        run_ok;
   logic        step_go;

   // Status
   logic        next_stage_writable;
   logic [15:0] main_status_register;
   logic [3:0]  step_pattern;

   // ************************************************************
   // Bus decode
   // ************************************************************
   assign wr_req   = cyc_i && stb_i && we_i && !ack_o;
   assign rd_req   = cyc_i && stb_i && !we_i && !ack_o;
   assign cmd_wr   = wr_req && (adr_i == OFS_CMD) && (sel_i[1:0] == 2'h3);
   assign cmd_code = dat_i[7:0];
   assign cmd_axis = dat_i[CMD_AXIS_LSB +: 2];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd_req) begin
         case (adr_i)
            OFS_DATA_LO: dat_o <= {16'h0000, data_low_register};
            OFS_DATA_HI: dat_o <= {16'h0000, data_high_register};
            OFS_CMD,
            OFS_STATUS:  dat_o <= {16'h0000, main_status_register};
            OFS_PERIOD:  dat_o <= {16'h0000, period};
            default:     dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ************************************************************
   // Software registers
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_low_register  <= 16'h0000;
         data_high_register <= 16'h0000;
         period             <= PERIOD_RST;
      end else if (wr_req) begin
         case (adr_i)
            OFS_DATA_LO: data_low_register <= bpi_merge(data_low_register, dat_i[15:0], sel_i[1:0]);
            OFS_DATA_HI: data_high_register <= bpi_merge(data_high_register, dat_i[15:0], sel_i[1:0]);
            OFS_PERIOD:  period <= bpi_merge(period, dat_i[15:0], sel_i[1:0]);
            default:     period <= period;
         endcase
      end
   end

   // Interpolation mode word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode <= MODE_RST;
      end else if (cmd_wr && cmd_code == CMD_MODE_SET) begin
         mode <= data_low_register;
      end
   end

   // Pattern staging per axis
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage_x <= 32'h0000_0000;
         stage_y <= 32'h0000_0000;
      end else if (cmd_wr && cmd_code == CMD_STAGE_DATA) begin
         if (cmd_axis[0]) begin
            stage_x <= {data_high_register, data_low_register};
         end
         if (cmd_axis[1]) begin
            stage_y <= {data_high_register, data_low_register};
         end
      end
   end

   // Start hold on the main axis
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold <= 1'b0;
      end else if (cmd_wr && cmd_axis[0]) begin
         if (cmd_code == CMD_HOLD_START) begin
            hold <= 1'b1;
         end else if (cmd_code == CMD_HOLD_RELEASE) begin
            hold <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Buffer control
   // ************************************************************
   assign push     = cmd_wr && cmd_code == CMD_BP_DRIVE && mode[MODE_EN_BIT];
   assign push_ok  = push && (count != CNT_FULL);
   assign stop_cmd = cmd_wr && cmd_axis[0] &&
                     (cmd_code == CMD_STOP_DECEL || cmd_code == CMD_STOP_INSTANT);
   assign run_ok   = (state == BPI_RUN) && !hold && (count != 4'h0);
   assign step_pattern = {head[PAT_W*3 + bit_idx], head[PAT_W*2 + bit_idx],
                          head[PAT_W + bit_idx], head[bit_idx]};
   assign end_code = (step_pattern[0] && step_pattern[1]) ||
                     (step_pattern[2] && step_pattern[3]);
   assign pop      = run_ok && tick && !end_code && (bit_idx == BIT_LAST);
   assign finish   = (state == BPI_RUN) &&
                     ((run_ok && tick && end_code) ||
                      stop_cmd ||
                      (limit_i != 4'h0) ||
                      (count == 4'h0 && !push));
   assign flush    = finish || stop_cmd;
   assign step_go  = run_ok && tick && !end_code && !finish;

   bpi_prebuffer u_prebuffer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .push_i  (push),
      .pop_i   (pop),
      .flush_i (flush),
      .data_i  ({stage_y, stage_x}),
      .head_o  (head),
      .count_o (count)
   );

   bpi_pacer u_pacer (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .en_i      (run_ok),
      .period_i  (period),
      .stretch_i (diag && mode[MODE_SPD_LO_BIT]),
      .tick_o    (tick)
   );

   // ************************************************************
   // Drive sequencer
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state   <= BPI_IDLE;
         started <= 1'b0;
      end else begin
         case (state)
            BPI_IDLE: begin
               if (push && !stop_cmd) begin
                  state   <= BPI_RUN;
                  started <= 1'b1;
               end
            end
            BPI_RUN: begin
               if (finish) begin
                  state   <= BPI_IDLE;
                  started <= 1'b0;
               end
            end
            default: begin
               state   <= BPI_IDLE;
               started <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || flush) begin
         bit_idx <= 4'h0;
      end else if (run_ok && tick) begin
         bit_idx <= bit_idx + 4'h1;
      end
   end

   // Step pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         x_plus_step_o  <= 1'b0;
         x_minus_step_o <= 1'b0;
         y_plus_step_o  <= 1'b0;
         y_minus_step_o <= 1'b0;
      end else begin
         x_plus_step_o  <= step_go && step_pattern[0];
         x_minus_step_o <= step_go && step_pattern[1];
         y_plus_step_o  <= step_go && step_pattern[2];
         y_minus_step_o <= step_go && step_pattern[3];
      end
   end

   // Diagonal step memory
   always_ff @(posedge clk_i) begin
      if (rst_i || flush) begin
         diag <= 1'b0;
      end else if (run_ok && tick) begin
         diag <= (step_pattern[0] || step_pattern[1]) &&
                 (step_pattern[2] || step_pattern[3]);
      end
   end

   // ************************************************************
   // Status and interrupt
   // ************************************************************
   assign next_stage_writable = started && (count != 4'h0) && (count <= CNT_LAST);
   assign main_status_register = {count, next_stage_writable, 9'h000,
                                  hold, (state == BPI_RUN)};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         driving_o <= 1'b0;
      end else begin
         driving_o <= (state == BPI_RUN) && !finish;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         continuous_interp_irq_n_o <= 1'b1;
      end else if (pop && !push_ok && (count == CNT_FULL || count == CNT_HALF) && !flush) begin
         continuous_interp_irq_n_o <= 1'b0;
      end else if (push_ok || finish) begin
         continuous_interp_irq_n_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- tb/bpi_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bpi_chk (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Register bus
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // Motion
   input wire logic [3:0]  limit_i,
   input wire logic        x_plus_step_o,
   input wire logic        x_minus_step_o,
   input wire logic        y_plus_step_o,
   input wire logic        y_minus_step_o,
   input wire logic        driving_o,
   input wire logic        continuous_interp_irq_n_o
);
   import bpi_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic stop_req;
   logic st_rd;
   // ************************************************************
   // Helpers
   // ************************************************************
   assign stop_req = cyc_i && stb_i && we_i && !ack_o && adr_i == OFS_CMD && sel_i[1:0] == 2'h3 &&
                     dat_i[9:8] == AXIS_X && (dat_i[7:0] == CMD_STOP_DECEL || dat_i[7:0] == CMD_STOP_INSTANT);
   always_ff @(posedge clk_i) begin
      st_rd <= cyc_i && stb_i && !we_i && adr_i == OFS_STATUS;
   end
   // ************************************************************
   // Assertions
   // ************************************************************
   chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not acknowledged");
   chk_steps_idle: assert property ((x_plus_step_o || x_minus_step_o || y_plus_step_o || y_minus_step_o)
      |-> $past(driving_o) || $past(driving_o, 2)) else $error("step pulse outside a run");
   chk_no_both: assert property (!(x_plus_step_o && x_minus_step_o) && !(y_plus_step_o && y_minus_step_o))
      else $error("both directions pulsed on one axis");
   chk_limit_stop: assert property (driving_o && limit_i != 4'h0 |-> ##[1:3] !driving_o)
      else $error("limit did not stop the run");
   chk_stop_flush: assert property (stop_req |-> ##[1:3] !driving_o)
      else $error("stop command did not stop the run");
   chk_irq_cause: assert property ($fell(continuous_interp_irq_n_o) |-> $past(driving_o))
      else $error("interrupt raised outside a run");
   chk_irq_finish: assert property (!driving_o && !$past(driving_o) |-> continuous_interp_irq_n_o)
      else $error("interrupt active while idle");
   chk_next_flag: assert property (ack_o && st_rd && dat_o[11] |-> dat_o[15:12] inside {[4'h1:4'h7]})
      else $error("next stage flag with count out of range");
   chk_count_max: assert property (ack_o && st_rd |-> dat_o[15:12] <= CNT_FULL)
      else $error("stack count above full");
endmodule
bind bpi_top bpi_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
   .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .limit_i(limit_i), .x_plus_step_o(x_plus_step_o),
   .x_minus_step_o(x_minus_step_o), .y_plus_step_o(y_plus_step_o), .y_minus_step_o(y_minus_step_o),
   .driving_o(driving_o), .continuous_interp_irq_n_o(continuous_interp_irq_n_o)
);
`default_nettype wire

//--- tb/bpi_host.sv
`timescale 1ns/1ps
`default_nettype none
module bpi_host (
   // Clock
   input  wire logic        clk_i,
   // Wishbone master
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o,
   input  wire logic [31:0] dat_i,
   input  wire logic        ack_i,
   // Hang flag
   output logic             hang_o
);
   import bpi_pkg::*;
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h3;
      dat_o = 32'h0;
      hang_o = 1'b0;
   end
   // ************************************************************
   // Bus cycles
   // ************************************************************
   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 100);
      if (ack_i !== 1'b1) hang_o <= 1'b1;
      q = dat_i[15:0];
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      xfer(1'b0, a, 16'h0000, q);
   endtask
   // Both axes loaded before the drive command commits the stage
   task automatic stage(input logic [15:0] xp, input logic [15:0] xm, input logic [15:0] yp, input logic [15:0] ym);
      wr(OFS_DATA_LO, xp);
      wr(OFS_DATA_HI, xm);
      wr(OFS_CMD, {6'h00, AXIS_X, CMD_STAGE_DATA});
      wr(OFS_DATA_LO, yp);
      wr(OFS_DATA_HI, ym);
      wr(OFS_CMD, {6'h00, AXIS_Y, CMD_STAGE_DATA});
      wr(OFS_CMD, {8'h00, CMD_BP_DRIVE});
   endtask
   // Step pace set in the shared period register
   task automatic pace(input logic [15:0] p);
      wr(OFS_PERIOD, p);
   endtask
endmodule
`default_nettype wire

//--- tb/bit_pattern_interp_prebuffer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bit_pattern_interp_prebuffer_tb;
   import bpi_pkg::*;
   typedef struct packed {logic [15:0] mode; logic [15:0] gap; logic [15:0] cnt;} bpi_row_t;
   localparam logic [15:0] GAP_V = 16'((16 * VEC_NUM) >> VEC_SHIFT);
   logic        clk_i;
   logic        rst_i;
   logic        cyc, stb, we, ack, hang;
   logic [7:0]  adr;
   logic [3:0]  sel, limit;
   logic [31:0] wdat, rdat;
   logic        xp, xm, yp, ym, drv, irq_n;
   logic [15:0] q;
   int          err_total, total_checks, cyc_n, xp_n, yp_n, xm_n, ym_n, last_t, gap_n, c, d;
   bpi_row_t    rows [4] = '{'{16'h0000, 16'h0000, 16'h0000}, '{16'h0001, 16'h0010, 16'h0002},
                             '{16'h0041, GAP_V, 16'h0002}, '{16'h00c1, GAP_V, 16'h0002}};
   logic [15:0] ab [6] = '{{6'h00, AXIS_X, CMD_STOP_DECEL}, {6'h00, AXIS_X, CMD_STOP_INSTANT},
                           16'h0001, 16'h0002, 16'h0004, 16'h0008};
   bpi_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
                .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .limit_i(limit), .x_plus_step_o(xp),
                .x_minus_step_o(xm), .y_plus_step_o(yp), .y_minus_step_o(ym), .driving_o(drv),
                .continuous_interp_irq_n_o(irq_n));
   bpi_host h (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat),
               .dat_i(rdat), .ack_i(ack), .hang_o(hang));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // ************************************************************
   // Pulse monitor and hang watch
   // ************************************************************
   always @(posedge clk_i) begin
      cyc_n++;
      if (xp === 1'b1) begin
         gap_n = cyc_n - last_t;
         last_t = cyc_n;
         xp_n++;
      end
      if (yp === 1'b1) yp_n++;
      if (xm === 1'b1) xm_n++;
      if (ym === 1'b1) ym_n++;
      if (hang === 1'b1) begin
         err_total++;
         results();
      end
   end
   task automatic results;
      if (err_total == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Wait for the run (k=0) or the interrupt (k=1) to go low
   task automatic wait_low(input bit k, input int lim);
      int n;
      n = 0;
      repeat (2) @(posedge clk_i);
      while ((k ? irq_n : drv) !== 1'b0 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      if ((k ? irq_n : drv) !== 1'b0) begin
         err_total++;
         results();
      end
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      rst_i = 1'b1;
      limit = 4'h0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("irq reset", 16'h0001, {15'h0, irq_n});
      chk("drive reset", 16'h0000, {15'h0, drv});
      h.rd(OFS_STATUS, q);
      chk("status reset", 16'h0000, q);
      h.rd(8'h20, q);
      chk("unmapped", 16'h0000, q);
      h.pace(16'h0010);
      h.rd(OFS_PERIOD, q);
      chk("period", 16'h0010, q);
      foreach (rows[i]) begin
         h.wr(OFS_DATA_LO, rows[i].mode);
         h.wr(OFS_CMD, {8'h00, CMD_MODE_SET});
         c = xp_n;
         d = yp_n;
         h.stage(16'h0003, 16'h0000, 16'h0003, 16'h0000);
         wait_low(0, 2000);
         chk("x pulses", rows[i].cnt, 16'(xp_n - c));
         chk("y pulses", rows[i].cnt, 16'(yp_n - d));
         if (rows[i].cnt != 0) chk("gap", rows[i].gap, 16'(gap_n));
      end
      h.wr(OFS_DATA_LO, 16'h0001);
      h.wr(OFS_CMD, {8'h00, CMD_MODE_SET});
      h.pace(16'h0002);
      for (int n = 8; n >= 4; n -= 4) begin
         h.wr(OFS_CMD, {6'h00, AXIS_X, CMD_HOLD_START});
         c = xp_n;
         repeat (n + n / 8) h.stage(16'h0001, 16'h0000, 16'h0000, 16'h0000);
         h.rd(OFS_STATUS, q);
         chk("count full", 16'(n), {12'h0, q[15:12]});
         chk("next full", 16'(n < 8), {15'h0, q[11]});
         chk("held", 16'h0000, 16'(xp_n - c));
         h.wr(OFS_CMD, {6'h00, AXIS_X, CMD_HOLD_RELEASE});
         wait_low(1, 500);
         h.rd(OFS_STATUS, q);
         chk("irq count", 16'(n - 1), {12'h0, q[15:12]});
         chk("next flag", 16'h0001, {15'h0, q[11]});
         h.stage(16'h0001, 16'h0000, 16'h0000, 16'h0000);
         chk("irq push", 16'h0001, {15'h0, irq_n});
         wait_low(0, 2000);
         chk("drained", 16'(n + 1), 16'(xp_n - c));
         chk("irq done", 16'h0001, {15'h0, irq_n});
      end
      h.wr(OFS_CMD, {6'h00, AXIS_X, CMD_HOLD_START});
      c = xp_n;
      h.stage(16'h0005, 16'h0004, 16'h0000, 16'h0000);
      h.stage(16'h0001, 16'h0000, 16'h0000, 16'h0000);
      h.wr(OFS_CMD, {6'h00, AXIS_X, CMD_HOLD_RELEASE});
      wait_low(0, 500);
      chk("end code", 16'h0001, 16'(xp_n - c));
      h.rd(OFS_STATUS, q);
      chk("end status", 16'h0000, q);
      c = xm_n;
      d = ym_n;
      h.stage(16'h0000, 16'h0003, 16'h0000, 16'h0001);
      wait_low(0, 500);
      chk("x minus", 16'h0002, 16'(xm_n - c));
      chk("y minus", 16'h0001, 16'(ym_n - d));
      foreach (ab[i]) begin
         c = xp_n;
         h.stage(16'hffff, 16'h0000, 16'h0000, 16'h0000);
         h.stage(16'hffff, 16'h0000, 16'h0000, 16'h0000);
         repeat (4) @(posedge clk_i);
         if (ab[i][8]) h.wr(OFS_CMD, ab[i]);
         else limit <= ab[i][3:0];
         wait_low(0, 50);
         h.rd(OFS_STATUS, q);
         chk("abort status", 16'h0000, q);
         chk("abort cut", 16'h0001, {15'h0, (xp_n - c) < 32});
         limit <= 4'h0;
      end
      results();
   end
endmodule
`default_nettype wire
